/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import wtac_pkg::*;
  localparam int DC = 4; // Short DIFS
  localparam int SC = 3; // Short slot
  logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, er, med_busy, is_au;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] rev;
  logic [3:0] bmin, bmax, amod_level, tx_level, lat, s_lvl;
  logic frame_valid, frame_done, tx_start, tx_rts, tx_done, tx_ok, tx_collision;
  logic eth_data_en, eth_session_kill, fail_en, busy_req, s_rts;
  logic [12:0] frame_len;
  wtac_kind_t frame_kind;
  wtac_pins_t pins;
  int err_count, num_checks, cyc, s_cyc, n_start, n_kill, t0, n0, e;
  assign pins = {med_busy, is_au, rev, bmin, bmax};
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  wtac_top #(.DIFS_CYCLES(DC), .SLOT_CYCLES(SC)) wtac_top_i (.ref_clk(ref_clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .frame_valid(frame_valid), .frame_len(frame_len),
    .frame_kind(frame_kind), .amod_level(amod_level), .frame_done(frame_done), .tx_start(tx_start),
    .tx_rts(tx_rts), .tx_level(tx_level), .tx_done(tx_done), .tx_ok(tx_ok), .tx_collision(tx_collision),
    .eth_data_en(eth_data_en), .eth_session_kill(eth_session_kill));
  wtac_medium wtac_medium_i (.ref_clk(ref_clk), .arst_n(arst_n), .tx_start(tx_start), .fail_en(fail_en),
    .busy_req(busy_req), .lat(lat), .busy(med_busy), .tx_done(tx_done), .tx_ok(tx_ok),
    .tx_collision(tx_collision));
  // Monitor: cycle count, start attributes, kill pulses
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (tx_start === 1'b1) begin
      n_start <= n_start + 1;
      s_cyc <= cyc;
      s_rts <= tx_rts;
      s_lvl <= tx_level;
    end
    if (eth_session_kill === 1'b1) n_kill <= n_kill + 1;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic hang();
    err_count++;
    $display("[ERR] %0t wait ran out", $time);
    report_and_stop();
  endtask : hang
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) hang();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    apb(1'b1, a, d);
    chk({31'h0, er}, {31'h0, ee});
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask : rdc
  task automatic do_reset(input logic au, input logic [1:0] rv, input logic [3:0] lo, input logic [3:0] hi);
    arst_n <= 1'b0;
    is_au <= au;
    rev <= rv;
    bmin <= lo;
    bmax <= hi;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
  endtask : do_reset
  // Offer one frame, carrier busy for bz cycles, wait for completion
  task automatic send(input logic [12:0] len, input wtac_kind_t k, input logic [3:0] am, input int bz);
    int i;
    frame_valid <= 1'b1;
    frame_len <= len;
    frame_kind <= k;
    amod_level <= am;
    busy_req <= (bz > 0);
    t0 = cyc;
    n0 = n_start;
    for (i = 0; i < 3000 && frame_done !== 1'b1; i++) begin
      @(posedge ref_clk);
      if (i == bz) busy_req <= 1'b0;
    end
    if (i >= 3000) hang();
    frame_valid <= 1'b0;
    @(posedge ref_clk);
    e = s_cyc - t0;
  endtask : send
  task automatic t_defaults();
    chk({31'h0, eth_data_en}, 32'h1);
    rdc(A_CTRL, 32'h3);
    rdc(A_THR, 32'h3C);
    rdc(A_CW, 32'h03FF000F);
    rdc(A_MOD, 32'h0801);
    rdc(A_RETRY, 32'hA);
  endtask : t_defaults
  task automatic t_refuse();
    wr(A_THR, 32'h13, 1'b1);
    wr(A_THR, 32'h899, 1'b1);
    wr(A_THR, 32'h898, 1'b0);
    rdc(A_THR, 32'h898);
    wr(A_CW, 32'h03FF0005, 1'b1);
    wr(A_CW, 32'h0003000F, 1'b1);
    wr(A_MOD, 32'h0901, 1'b1);
    wr(A_STAT, 32'h0, 1'b1);
    rdc(8'h18, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask : t_refuse
  task automatic t_rts();
    wr(A_CTRL, 32'h1, 1'b0);
    wr(A_THR, 32'h64, 1'b0);
    send(13'd99, K_UNI, 4'h3, 0);
    chk({31'h0, s_rts}, 32'h0);
    chk({28'h0, s_lvl}, 32'h8);
    send(13'd100, K_UNI, 4'h3, 0);
    chk({31'h0, s_rts}, 32'h1);
    send(13'd40, K_MGMT, 4'h3, 0);
    chk({28'h0, s_lvl}, 32'h1);
  endtask : t_rts
  task automatic t_timing();
    wr(A_CW, 32'h03FF0000, 1'b0);
    send(13'd40, K_UNI, 4'h3, 0);
    chk(32'(e >= DC && e <= DC + 8), 32'h1);
    send(13'd40, K_UNI, 4'h3, 20);
    chk(32'(e >= DC + 20 && e <= DC + 30), 32'h1);
    wr(A_CW, 32'h03FF0007, 1'b0);
    send(13'd40, K_UNI, 4'h3, 0);
    chk(32'(e >= DC && e <= DC + 7 * SC + 8), 32'h1);
  endtask : t_timing
  // Each attempt: read window bound, check level kept
  task automatic watch();
    int k, i;
    @(posedge ref_clk);
    for (k = 0; k < 3; k++) begin
      for (i = 0; i < 500 && n_start < n0 + k + 1; i++) @(posedge ref_clk);
      if (i >= 500) hang();
      apb(1'b0, A_STAT, 32'h0);
      chk({22'h0, rd[15:6]}, (k == 0) ? 32'h7 : 32'hF);
      chk({28'h0, s_lvl}, 32'h5);
      amod_level <= 4'h2;
    end
  endtask : watch
  task automatic t_retry();
    wr(A_CTRL, 32'h3, 1'b0);
    wr(A_RETRY, 32'h2, 1'b0);
    wr(A_CW, 32'h000F0007, 1'b0);
    fail_en <= 1'b1;
    lat <= 4'h8;
    fork
      send(13'd40, K_UNI, 4'h5, 0);
      watch();
    join
    chk(n_start - n0, 32'h3);
    fail_en <= 1'b0;
    // Maximum level as for mid SIGNAL_TO_NOISE_RATIO
    wr(A_MOD, 32'h0501, 1'b0);
    send(13'd40, K_UNI, 4'h8, 0);
    chk(32'(s_lvl <= 4'h5), 32'h1);
  endtask : t_retry
  task automatic t_gate();
    int k0;
    k0 = n_kill;
    wr(A_CTRL, 32'h2, 1'b0);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, eth_data_en}, 32'h0);
    wr(A_CTRL, 32'h2, 1'b0);
    repeat (2) @(posedge ref_clk);
    chk(n_kill - k0, 32'h1);
    wr(A_CTRL, 32'h3, 1'b0);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, eth_data_en}, 32'h1);
  endtask : t_gate
  task automatic t_au();
    do_reset(1'b1, REV_A, 4'h2, 4'h8);
    rdc(A_THR, 32'h898);
    rdc(A_MOD, 32'h0702);
    wr(A_MOD, 32'h0802, 1'b1);
    wr(A_MOD, 32'h0703, 1'b0);
    fail_en <= 1'b1;
    send(13'd40, K_MULTI, 4'h6, 0);
    chk(n_start - n0, 32'h1);
    chk({28'h0, s_lvl}, 32'h3);
    fail_en <= 1'b0;
    send(13'd40, K_MGMT, 4'h6, 0);
    chk({28'h0, s_lvl}, 32'h2);
    wr(A_CTRL, 32'h0, 1'b0);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, eth_data_en}, 32'h1);
  endtask : t_au
  // Main sequence
  initial begin
    {arst_n, psel, penable, pwrite, frame_valid, fail_en, busy_req} = '0;
    {is_au, rev, bmin, bmax, paddr, pwdata} = '0;
    {frame_len, amod_level, lat} = '0;
    frame_kind = K_UNI;
    {err_count, num_checks, cyc, n_start, n_kill} = '0;
    @(posedge ref_clk);
    do_reset(1'b0, 2'h1, 4'h1, 4'h8);
    t_defaults();
    t_refuse();
    t_rts();
    t_timing();
    t_retry();
    t_gate();
    t_au();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire

/* wtac_medium.sv */
`timescale 1ns/1ps
`default_nettype none
// Shared medium: answers each radio start lat+1 cycles after it is sampled
module wtac_medium (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic tx_start,
  input wire logic fail_en,
  input wire logic busy_req,
  input wire logic [3:0] lat,
  output logic busy,
  output logic tx_done,
  output logic tx_ok,
  output logic tx_collision
);
  logic act_reg; // Transmission in flight
  logic tgl_reg; // Filler pattern outside answers
  logic [3:0] cnt_reg; // Cycles left before the answer
  // Carrier comes from the bench schedule
  assign busy = busy_req;
  // Answer timing; status lines carry junk between answers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      act_reg <= 1'b0;
      tgl_reg <= 1'b0;
      cnt_reg <= 4'h0;
      tx_done <= 1'b0;
      tx_ok <= 1'b0;
      tx_collision <= 1'b0;
    end else begin
      tgl_reg <= ~tgl_reg;
      tx_done <= 1'b0;
      tx_ok <= tgl_reg;
      tx_collision <= ~tgl_reg;
      if (tx_start) begin
        act_reg <= 1'b1;
        cnt_reg <= lat;
      end else if (act_reg && cnt_reg == 4'h0) begin
        act_reg <= 1'b0;
        tx_done <= 1'b1;
        tx_ok <= ~fail_en;
        tx_collision <= fail_en;
      end else if (act_reg) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule : wtac_medium
`default_nettype wire

/* wtac_pkg.sv */
// Overview of operation
// - Subscriber wired gate blocks data, passes management
// - Gate disable kills running data sessions
// - RTS first when frame size reaches threshold
// - Threshold range 20 up to revision limit
// - Threshold default 60 or hardware maximum
// - Draw random slot count zero to C
// - Wait DIFS plus slots, defer when busy
// - Collision steps C up, capped at maximum
// - Each new frame loads C from minimum
// - Minimum window legal values, default 15
// - Minimum zero skips back-off after DIFS
// - Maximum window caps C, default 1023
// - Multicast at multicast level on access units only, never retried
// - Management frames at lowest sub-band level
// - Level settings capped 7 or 8
// - Multicast level defaults to sub-band lowest
// - Fixed unicast level when adaptation off
// - Adaptive level never above maximum level
// - Maximum level defaults to highest supported
// - Retry at same level, count 1 to 14
package wtac_pkg;
  // Timing
  localparam int CLK_NS = 50;
  localparam int DIFS_NS = 50000;
  localparam int SLOT_NS = 20000;
  localparam int DIFS_CYC = (DIFS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLOT_CYC = (SLOT_NS + CLK_NS - 1) / CLK_NS;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_THR = 8'h04;
  localparam logic [7:0] A_CW = 8'h08;
  localparam logic [7:0] A_MOD = 8'h0C;
  localparam logic [7:0] A_RETRY = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  // Field positions
  localparam int F_GATE = 0;
  localparam int F_ADAPT = 1;
  localparam int F_CWMAX = 16;
  localparam int F_MODMAX = 8;
  // Reset and range values
  localparam logic [12:0] THR_SU = 13'h003C;
  localparam logic [12:0] THR_MIN = 13'h0014;
  localparam logic [12:0] THR_C = 13'h0FC0;
  localparam logic [12:0] THR_AB = 13'h0898;
  localparam logic [9:0] CW_MIN_RST = 10'h00F;
  localparam logic [9:0] CW_MAX_RST = 10'h3FF;
  localparam logic [9:0] CW_LOW = 10'h007;
  localparam logic [3:0] RETRY_RST = 4'hA;
  localparam logic [3:0] RETRY_MAX = 4'hE;
  localparam logic [3:0] LVL_CAP_A = 4'h7;
  localparam logic [3:0] LVL_CAP_B = 4'h8;
  localparam logic [1:0] REV_A = 2'h0;
  localparam logic [1:0] REV_C = 2'h2;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  // Frame kinds
  typedef enum logic [1:0] {K_UNI, K_MULTI, K_MGMT} wtac_kind_t;
  // Access states
  typedef enum logic [2:0] {ST_IDLE, ST_DIFS, ST_BACKOFF, ST_WAIT} wtac_fsm_t;
  // Pins from outside the clock domain
  typedef struct packed {
    logic busy;
    logic is_au;
    logic [1:0] rev;
    logic [3:0] bmin;
    logic [3:0] bmax;
  } wtac_pins_t;
  // Whole module state
  typedef struct packed {
    wtac_pins_t s1;
    wtac_pins_t s2;
    logic [1:0] init;
    logic gate_en;
    logic adapt_en;
    logic [12:0] thr;
    logic [9:0] cw_min;
    logic [9:0] cw_max;
    logic [9:0] cw;
    logic [3:0] mc_lvl;
    logic [3:0] max_lvl;
    logic [3:0] retry_lim;
    logic [3:0] retries;
    logic [15:0] lfsr;
    wtac_fsm_t fsm;
    logic [15:0] cnt;
    logic [9:0] n_left;
    logic drawn;
    logic [12:0] len;
    wtac_kind_t kind;
    logic [3:0] lvl;
    logic rts;
    logic tx_start;
    logic done;
    logic kill;
    logic data_en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } wtac_state_t;
endpackage : wtac_pkg

/* wtac_top.sv */
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module wtac_top #(
  parameter int DIFS_CYCLES = wtac_pkg::DIFS_CYC,
  parameter int SLOT_CYCLES = wtac_pkg::SLOT_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire wtac_pkg::wtac_pins_t pins,
  input wire logic frame_valid,
  input wire logic [12:0] frame_len,
  input wire wtac_pkg::wtac_kind_t frame_kind,
  input wire logic [3:0] amod_level,
  output logic frame_done,
  output logic tx_start,
  output logic tx_rts,
  output logic [3:0] tx_level,
  input wire logic tx_done,
  input wire logic tx_ok,
  input wire logic tx_collision,
  output logic eth_data_en,
  output logic eth_session_kill
);
  import wtac_pkg::*;

  wtac_state_t st_reg;
  wtac_state_t st_next;

  // Legal window value: 2^k-1, 7..1023
  function automatic logic cw_ok(input logic [9:0] v);
    cw_ok = ((v & (v + 10'h001)) == 10'h000) && (v >= CW_LOW);
  endfunction : cw_ok

  // Next window bound, capped
  function automatic logic [9:0] cw_step(input logic [9:0] c, input logic [9:0] mx);
    logic [9:0] n;
    n = {c[8:0], 1'b1} | CW_LOW;
    cw_step = (n > mx) ? mx : n;
  endfunction : cw_step

  // Smaller of two windows
  function automatic logic [9:0] cw_lo(input logic [9:0] a, input logic [9:0] b);
    cw_lo = (a > b) ? b : a;
  endfunction : cw_lo

  // Clamp a level into a range
  function automatic logic [3:0] clamp(input logic [3:0] v, input logic [3:0] lo, input logic [3:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  // Derived limits from straps
  logic [3:0] lvl_hi;
  logic [12:0] thr_hi;
  logic busy;
  logic [9:0] draw;
  logic setup;
  logic access;
  logic go_tx;
  logic [31:0] wd;

  // Limits and helpers
  always_comb begin
    lvl_hi = (st_reg.s2.rev == REV_A) ? LVL_CAP_A : LVL_CAP_B;
    if (st_reg.s2.bmax < lvl_hi) begin
      lvl_hi = st_reg.s2.bmax;
    end
    thr_hi = (st_reg.s2.rev == REV_C) ? THR_C : THR_AB;
    busy = st_reg.s2.busy;
    draw = st_reg.lfsr[9:0] & st_reg.cw;
    setup = psel && !penable;
    access = psel && penable && st_reg.pready;
    wd = pwdata;
  end

  // Next state
  always_comb begin
    st_next = st_reg;
    go_tx = 1'b0;
    // Synchroniser stages
    st_next.s1 = pins;
    st_next.s2 = st_reg.s1;
    st_next.lfsr = {st_reg.lfsr[14:0], st_reg.lfsr[15] ^ st_reg.lfsr[13] ^ st_reg.lfsr[12] ^ st_reg.lfsr[10]};
    st_next.tx_start = 1'b0;
    st_next.done = 1'b0;
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    // Strap-dependent defaults once settled
    if (st_reg.init != 2'h3) begin
      st_next.init = st_reg.init + 2'h1;
    end
    if (st_reg.init == 2'h2) begin
      st_next.thr = st_reg.s2.is_au ? thr_hi : THR_SU;
      st_next.mc_lvl = st_reg.s2.bmin;
      st_next.max_lvl = lvl_hi;
    end
    // APB setup: decode, answer next cycle
    if (setup) begin
      st_next.pready = 1'b1;
      st_next.prdata = 32'h0000_0000;
      unique case (paddr)
        A_CTRL: begin
          st_next.prdata[F_GATE] = st_reg.gate_en;
          st_next.prdata[F_ADAPT] = st_reg.adapt_en;
        end
        A_THR: begin
          st_next.prdata[12:0] = st_reg.thr;
          st_next.pslverr = pwrite && (wd[12:0] < THR_MIN || wd[12:0] > thr_hi || wd[31:13] != 19'h0);
        end
        A_CW: begin
          st_next.prdata = {6'h00, st_reg.cw_max, 6'h00, st_reg.cw_min};
          st_next.pslverr = pwrite && (!(cw_ok(wd[9:0]) || wd[9:0] == 10'h000) || !cw_ok(wd[25:16]));
        end
        A_MOD: begin
          st_next.prdata = {20'h00000, st_reg.max_lvl, 4'h0, st_reg.mc_lvl};
          st_next.pslverr = pwrite && (wd[3:0] < st_reg.s2.bmin || wd[3:0] > lvl_hi ||
                            wd[11:8] < st_reg.s2.bmin || wd[11:8] > lvl_hi);
        end
        A_RETRY: begin
          st_next.prdata[3:0] = st_reg.retry_lim;
          st_next.pslverr = pwrite && (wd[3:0] == 4'h0 || wd[3:0] > RETRY_MAX);
        end
        A_STAT: begin
          st_next.prdata = {9'h000, st_reg.fsm, st_reg.retries, st_reg.cw, 2'h0, st_reg.lvl};
          st_next.pslverr = pwrite;
        end
        default: begin
          // Unmapped address
          st_next.pslverr = 1'b1;
        end
      endcase
    end
    // APB access: commit legal writes
    if (access && pwrite && !st_reg.pslverr) begin
      unique case (paddr)
        A_CTRL: begin
          st_next.gate_en = wd[F_GATE];
          st_next.adapt_en = wd[F_ADAPT];
        end
        A_THR: begin
          st_next.thr = wd[12:0];
        end
        A_CW: begin
          st_next.cw_min = wd[9:0];
          st_next.cw_max = wd[F_CWMAX +: 10];
        end
        A_MOD: begin
          st_next.mc_lvl = wd[3:0];
          st_next.max_lvl = wd[F_MODMAX +: 4];
        end
        A_RETRY: begin
          st_next.retry_lim = wd[3:0];
        end
        default: begin
          // Read-only status
          st_next.retry_lim = st_reg.retry_lim;
        end
      endcase
    end
    // Medium access machine
    unique case (st_reg.fsm)
      ST_IDLE: begin
        // New frame from bridge queue
        if (frame_valid && !st_reg.done) begin
          st_next.len = frame_len;
          st_next.kind = frame_kind;
          st_next.cw = cw_lo(st_reg.cw_min, st_reg.cw_max);
          st_next.retries = 4'h0;
          st_next.drawn = 1'b0;
          st_next.cnt = 16'h0000;
          st_next.fsm = ST_DIFS;
          if (frame_kind == K_MGMT) begin
            st_next.lvl = st_reg.s2.bmin;
          end else if (frame_kind == K_MULTI && st_reg.s2.is_au) begin
            st_next.lvl = st_reg.mc_lvl;
          end else if (st_reg.adapt_en) begin
            st_next.lvl = clamp(amod_level, st_reg.s2.bmin, st_reg.max_lvl);
          end else begin
            st_next.lvl = st_reg.max_lvl;
          end
        end
      end
      ST_DIFS: begin
        if (busy) begin
          st_next.cnt = 16'h0000;
        end else if (st_reg.cnt == 16'(DIFS_CYCLES - 1)) begin
          st_next.cnt = 16'h0000;
          if (st_reg.drawn) begin
            go_tx = (st_reg.n_left == 10'h000);
          end else if (st_reg.cw_min == 10'h000) begin
            go_tx = 1'b1;
          end else begin
            st_next.n_left = draw;
            st_next.drawn = 1'b1;
            go_tx = (draw == 10'h000);
          end
          if (!go_tx) begin
            st_next.fsm = ST_BACKOFF;
          end
        end else begin
          st_next.cnt = st_reg.cnt + 16'h0001;
        end
      end
      ST_BACKOFF: begin
        if (busy) begin
          st_next.cnt = 16'h0000;
          st_next.fsm = ST_DIFS;
        end else if (st_reg.cnt == 16'(SLOT_CYCLES - 1)) begin
          st_next.cnt = 16'h0000;
          st_next.n_left = st_reg.n_left - 10'h001;
          go_tx = (st_reg.n_left == 10'h001);
        end else begin
          st_next.cnt = st_reg.cnt + 16'h0001;
        end
      end
      ST_WAIT: begin
        // Outcome from radio
        if (tx_done) begin
          if (!tx_ok && st_reg.kind != K_MULTI && st_reg.retries < st_reg.retry_lim) begin
            st_next.retries = st_reg.retries + 4'h1;
            st_next.drawn = 1'b0;
            st_next.cnt = 16'h0000;
            st_next.fsm = ST_DIFS;
            if (tx_collision) begin
              st_next.cw = cw_step(st_reg.cw, st_reg.cw_max);
            end
          end else begin
            st_next.done = 1'b1;
            st_next.fsm = ST_IDLE;
          end
        end
      end
    endcase
    // Launch a transmission
    if (go_tx) begin
      st_next.tx_start = 1'b1;
      st_next.rts = (st_reg.len >= st_reg.thr);
      st_next.fsm = ST_WAIT;
    end
    st_next.kill = st_reg.gate_en && !st_next.gate_en;
    st_next.data_en = st_next.gate_en || st_reg.s2.is_au;
  end

  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.gate_en <= 1'b1;
      st_reg.data_en <= 1'b1;
      st_reg.adapt_en <= 1'b1;
      st_reg.thr <= THR_SU;
      st_reg.cw_min <= CW_MIN_RST;
      st_reg.cw_max <= CW_MAX_RST;
      st_reg.cw <= CW_MIN_RST;
      st_reg.retry_lim <= RETRY_RST;
      st_reg.lfsr <= LFSR_SEED;
      st_reg.fsm <= ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs from flops
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign frame_done = st_reg.done;
  assign tx_start = st_reg.tx_start;
  assign tx_rts = st_reg.rts;
  assign tx_level = st_reg.lvl;
  // Gate level from its own flop
  assign eth_data_en = st_reg.data_en;
  assign eth_session_kill = st_reg.kill;

  // Checks
  // Frame taken from the bridge queue
  sequence s_take;
    st_reg.fsm == ST_IDLE && frame_valid && !st_reg.done;
  endsequence
  // Failed attempt that earns a retry
  sequence s_fail_retry;
    st_reg.fsm == ST_WAIT && tx_done && !tx_ok && st_reg.kind != K_MULTI && st_reg.retries < st_reg.retry_lim;
  endsequence
  // Failed attempt with no retry left
  sequence s_fail_drop;
    st_reg.fsm == ST_WAIT && tx_done && !tx_ok && st_reg.kind != K_MULTI && st_reg.retries >= st_reg.retry_lim;
  endsequence
  // Multicast outcome of any kind
  sequence s_mc_fail;
    st_reg.fsm == ST_WAIT && tx_done && st_reg.kind == K_MULTI;
  endsequence
  gate_su_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_reg.init == 2'h3 && !st_reg.s2.is_au |-> eth_data_en == st_reg.gate_en) else $error("subscriber gate");
  gate_au_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_reg.init == 2'h3 && st_reg.s2.is_au |-> eth_data_en) else $error("access unit gated");
  gate_kill_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $fell(st_reg.gate_en) |-> eth_session_kill ##1 !eth_session_kill) else $error("no kill pulse");
  rts_pick_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tx_start |-> tx_rts == (st_reg.len >= st_reg.thr)) else $error("rts choice wrong");
  thr_range_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_reg.init == 2'h3 |-> st_reg.thr >= THR_MIN && st_reg.thr <= thr_hi) else $error("threshold out of range");
  thr_dflt_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_reg.init == 2'h2 |=> st_reg.thr == (st_reg.s2.is_au ? thr_hi : THR_SU)) else $error("threshold default");
  draw_bound_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_reg.fsm == ST_BACKOFF |-> st_reg.n_left <= st_reg.cw && st_reg.n_left != 10'h000) else $error("bad draw");
  difs_busy_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_reg.fsm == ST_DIFS && busy |=> st_reg.cnt == 16'h0000 && !tx_start) else $error("difs not restarted");
  busy_defer_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_reg.fsm == ST_BACKOFF && busy |=> st_reg.fsm == ST_DIFS && !tx_start) else $error("no defer");
  cw_step_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_fail_retry and tx_collision |=> st_reg.cw == cw_step($past(st_reg.cw), st_reg.cw_max)) else $error("cw step");
  cw_load_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_take |=> st_reg.cw == cw_lo(st_reg.cw_min, st_reg.cw_max)) else $error("cw not loaded");
  zero_win_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_reg.fsm == ST_DIFS && st_reg.cw_min == 10'h000 && !st_reg.drawn |=> st_reg.fsm != ST_BACKOFF)
    else $error("zero window backed off");
  cw_cap_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_reg.fsm != ST_IDLE |-> st_reg.cw <= st_reg.cw_max) else $error("window above maximum");
  mc_noretry_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_mc_fail |=> frame_done && st_reg.fsm == ST_IDLE) else $error("multicast retried");
  mgmt_lvl_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tx_start && st_reg.kind == K_MGMT |-> tx_level == st_reg.s2.bmin) else $error("mgmt level");
  mc_dflt_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_reg.init == 2'h2 |=> st_reg.mc_lvl == st_reg.s2.bmin) else $error("multicast level default");
  fixed_lvl_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_take ##0 (frame_kind == K_UNI && !st_reg.adapt_en) |=> tx_level == $past(st_reg.max_lvl))
    else $error("fixed level wrong");
  uni_cap_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tx_start && st_reg.kind == K_UNI |-> tx_level <= st_reg.max_lvl) else $error("unicast above max");
  max_dflt_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_reg.init == 2'h2 |=> st_reg.max_lvl == lvl_hi) else $error("maximum level default");
  retry_lvl_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_fail_retry |=> $stable(tx_level) && st_reg.retries == $past(st_reg.retries) + 4'h1) else $error("retry");
  retry_drop_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_fail_drop |=> frame_done && st_reg.fsm == ST_IDLE) else $error("frame not dropped");
endmodule : wtac_top
`default_nettype wire
